// >>> hdl/tpd_pkg.sv
package tpd_pkg;

	localparam logic [7:0] ADDR_TAP_CONFIG = 8'h21;
	localparam logic [7:0] ADDR_TAP_SOURCE = 8'h22;
	localparam logic [7:0] ADDR_TAP_THRESHOLD_X = 8'h23;
	localparam logic [7:0] ADDR_TAP_THRESHOLD_Y = 8'h24;
	localparam logic [7:0] ADDR_TAP_THRESHOLD_Z = 8'h25;
	localparam logic [7:0] ADDR_TAP_TIME_LIMIT = 8'h26;

	localparam int CFG_DOUBLE_TAP_ABORT_BIT = 7;
	localparam int CFG_FLAG_LATCH_ENABLE_BIT = 6;
	localparam int SRC_EVENT_ACTIVE_BIT = 7;
	localparam int SRC_AXIS_EVENT_LSB = 4;
	localparam int SRC_DOUBLE_TAP_FLAG_BIT = 3;
	localparam int SRC_POLARITY_LSB = 0;

	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [6:0] THRESHOLD_MAX_LOW_NOISE = 7'h3f;

	// Step tables are kept in multiples of this base unit
	localparam int STEP_UNIT_PS = 625000;
	localparam int CLK_PERIOD_PS = 40000;
	localparam int STEP_UNIT_CYCLES = STEP_UNIT_PS / CLK_PERIOD_PS;

	typedef enum logic [1:0] {
		OS_NORMAL = 2'b00,
		OS_LOW_NOISE_LOW_POWER = 2'b01,
		OS_HIGH_RESOLUTION = 2'b10,
		OS_LOW_POWER = 2'b11
	} tpd_os_type;

	typedef enum logic [2:0] {
		ODR_800 = 3'b000,
		ODR_400 = 3'b001,
		ODR_200 = 3'b010,
		ODR_100 = 3'b011,
		ODR_50 = 3'b100,
		ODR_12P5 = 3'b101,
		ODR_6P25 = 3'b110,
		ODR_1P56 = 3'b111
	} tpd_odr_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_FIRST_PULSE = 3'b001,
		ST_LATENCY = 3'b010,
		ST_WINDOW = 3'b011,
		ST_SECOND_PULSE = 3'b100,
		ST_WAIT_LOW = 3'b101
	} tpd_state_type;

	// Step length in base units (0.625 us)
	function automatic logic [8:0] stepUnits(input tpd_odr_type output_data_rate,
		input tpd_os_type os, input logic lowpass);
		logic [8:0] base;
		base = 9'h020;
		unique case (output_data_rate)
			ODR_800: base = 9'h002;
			ODR_400: base = 9'h004;
			ODR_200: base = 9'h008;
			ODR_100: base = 9'h010;
			ODR_50: base = 9'h020;
			ODR_12P5, ODR_6P25, ODR_1P56: begin
				if (os == OS_LOW_NOISE_LOW_POWER || os == OS_LOW_POWER)
					base = 9'h080;
				else
					base = 9'h020;
				if (os == OS_LOW_POWER && output_data_rate != ODR_12P5)
					base = 9'h100;
			end
		endcase
		if (os == OS_HIGH_RESOLUTION && output_data_rate != ODR_800)
			base = 9'h004;
		if (!lowpass)
			base = base >> 1;
		return base;
	endfunction

endpackage

// >>> hdl/tpd_step_gen.sv
module tpd_step_gen import tpd_pkg::*; #(
	parameter int UNIT_CYCLES = STEP_UNIT_CYCLES
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [8:0] stepLen,
	output logic stepTick
);

	initial begin
		if (UNIT_CYCLES < 1 || UNIT_CYCLES > 65535)
			$error("UNIT_CYCLES out of range");
	end

	logic [15:0] unitCnt_ff, nxt_unitCnt;
	logic [8:0] multCnt_ff, nxt_multCnt;
	logic tick_ff, nxt_tick;
	logic unitWrap;

	always_comb begin
		unitWrap = (unitCnt_ff == 16'(UNIT_CYCLES - 1));
		nxt_unitCnt = unitWrap ? 16'h0000 : unitCnt_ff + 16'h0001;
		nxt_multCnt = multCnt_ff;
		nxt_tick = 1'b0;
		if (unitWrap) begin
			// Range check covers a rate change mid-step
			if (multCnt_ff + 9'h001 >= stepLen) begin
				nxt_multCnt = 9'h000;
				nxt_tick = 1'b1;
			end else begin
				nxt_multCnt = multCnt_ff + 9'h001;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			unitCnt_ff <= 16'h0000;
			multCnt_ff <= 9'h000;
			tick_ff <= 1'b0;
		end else begin
			unitCnt_ff <= nxt_unitCnt;
			multCnt_ff <= nxt_multCnt;
			tick_ff <= nxt_tick;
		end
	end

	assign stepTick = tick_ff;

endmodule // tpd_step_gen

// >>> hdl/tpd_axis_detector.sv
module tpd_axis_detector import tpd_pkg::*; #(
	parameter int DATA_W = 8
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic sampleValid,
	input wire logic [DATA_W-1:0] accel,
	input wire logic [6:0] threshold,
	input wire logic stepTick,
	input wire logic [7:0] pulseTimeLimit,
	input wire logic [7:0] tapLatency,
	input wire logic [7:0] secondTapWindow,
	input wire logic doubleTapAbort,
	input wire logic singleEnable,
	input wire logic doubleEnable,
	output logic singleEvt,
	output logic doubleEvt,
	output logic polarity
);

	initial begin
		if (DATA_W < 8)
			$error("DATA_W must be at least 8");
	end

	tpd_state_type state_ff, nxt_state;
	logic [7:0] cnt_ff, nxt_cnt;
	logic pol_ff, nxt_pol;
	logic latAbove_ff, nxt_latAbove;
	logic abortHit_ff, nxt_abortHit;
	logic single_ff, nxt_single;
	logic double_ff, nxt_double;
	logic [DATA_W-1:0] mag;
	logic above, below, timeUp;

	always_comb begin
		mag = accel[DATA_W-1] ? DATA_W'(-accel) : accel;
		above = sampleValid && (mag > DATA_W'(threshold));
		below = sampleValid && !(mag > DATA_W'(threshold));
		timeUp = stepTick && (cnt_ff == pulseTimeLimit);
		nxt_state = state_ff;
		nxt_cnt = stepTick ? cnt_ff + 8'h01 : cnt_ff;
		nxt_pol = pol_ff;
		nxt_latAbove = latAbove_ff;
		nxt_abortHit = abortHit_ff;
		nxt_single = 1'b0;
		nxt_double = 1'b0;
		unique case (state_ff)
			ST_IDLE: begin
				nxt_cnt = 8'h00;
				if (above) begin
					nxt_state = ST_FIRST_PULSE;
					nxt_pol = accel[DATA_W-1];
				end
			end
			ST_FIRST_PULSE: begin
				if (timeUp) begin
					nxt_state = ST_WAIT_LOW;
				end else if (below) begin
					nxt_single = singleEnable;
					nxt_state = ST_LATENCY;
					nxt_cnt = 8'h00;
					nxt_latAbove = 1'b0;
					nxt_abortHit = 1'b0;
				end
			end
			ST_LATENCY: begin
				// Pulses here are watched for the abort case and to pick ST_WAIT_LOW on exit
				if (above)
					nxt_latAbove = 1'b1;
				if (below && latAbove_ff && doubleTapAbort)
					nxt_abortHit = 1'b1;
				if (stepTick && cnt_ff == tapLatency) begin
					nxt_cnt = 8'h00;
					if (doubleEnable && !abortHit_ff)
						nxt_state = ST_WINDOW;
					else
						nxt_state = latAbove_ff ? ST_WAIT_LOW : ST_IDLE;
				end
			end
			ST_WINDOW: begin
				if (above) begin
					nxt_state = ST_SECOND_PULSE;
					nxt_cnt = 8'h00;
					nxt_pol = accel[DATA_W-1];
				end else if (stepTick && cnt_ff == secondTapWindow) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_SECOND_PULSE: begin
				// End of second pulse may fall after the window
				if (timeUp) begin
					nxt_state = ST_WAIT_LOW;
				end else if (below) begin
					nxt_double = doubleEnable;
					nxt_state = ST_IDLE;
				end
			end
			ST_WAIT_LOW: begin
				if (below)
					nxt_state = ST_IDLE;
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state_ff <= ST_IDLE;
			cnt_ff <= 8'h00;
			pol_ff <= 1'b0;
			latAbove_ff <= 1'b0;
			abortHit_ff <= 1'b0;
			single_ff <= 1'b0;
			double_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			pol_ff <= nxt_pol;
			latAbove_ff <= nxt_latAbove;
			abortHit_ff <= nxt_abortHit;
			single_ff <= nxt_single;
			double_ff <= nxt_double;
		end
	end

	assign singleEvt = single_ff;
	assign doubleEvt = double_ff;
	assign polarity = pol_ff;

endmodule // tpd_axis_detector

// >>> hdl/tpd_tap_pulse_detector.sv
module tpd_tap_pulse_detector import tpd_pkg::*; #(
	parameter int UNIT_CYCLES = STEP_UNIT_CYCLES
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic sampleValid,
	input wire logic [7:0] accelX,
	input wire logic [7:0] accelY,
	input wire logic [7:0] accelZ,
	input wire logic [2:0] outputDataRate,
	input wire logic [1:0] oversampleMode,
	input wire logic tapLowpassEnable,
	input wire logic lowNoise,
	input wire logic [7:0] tapLatency,
	input wire logic [7:0] secondTapWindow,
	input wire logic [7:0] regAddr,
	input wire logic regWrEn,
	input wire logic [7:0] regWrData,
	input wire logic regRdEn,
	output logic [7:0] regRdData,
	output logic tapIrq
);

	logic [7:0] cfg_ff, nxt_cfg;
	logic [7:0] src_ff, nxt_src;
	logic [2:0][6:0] ths_ff, nxt_ths;
	logic [7:0] timeLimit_ff, nxt_timeLimit;
	logic [7:0] rdData_ff, nxt_rdData;
	logic irq_ff, nxt_irq;

	logic [2:0][7:0] accel;
	logic [2:0][6:0] effThs;
	logic [2:0] singleEvt, doubleEvt, pol;
	logic [8:0] stepLen;
	logic stepTick;
	logic anySingle, anyDouble, anyEvt, srcRead, latchOn;

	assign accel = {accelZ, accelY, accelX};

	// 8-bit samples at 0.063 g/count span 8 g, independent of full scale
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			effThs[i] = ths_ff[i];
			if (lowNoise && ths_ff[i] > THRESHOLD_MAX_LOW_NOISE)
				effThs[i] = THRESHOLD_MAX_LOW_NOISE;
		end
		stepLen = stepUnits(tpd_odr_type'(outputDataRate),
			tpd_os_type'(oversampleMode), tapLowpassEnable);
	end

	tpd_step_gen #(
		.UNIT_CYCLES(UNIT_CYCLES)
	) u_step (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.stepLen(stepLen),
		.stepTick(stepTick)
	);

	for (genvar g = 0; g < 3; g++) begin : g_axis
		tpd_axis_detector #(
			.DATA_W(8)
		) u_axis (
			.sys_clk(sys_clk),
			.reset_n(reset_n),
			.sampleValid(sampleValid),
			.accel(accel[g]),
			.threshold(effThs[g]),
			.stepTick(stepTick),
			.pulseTimeLimit(timeLimit_ff),
			.tapLatency(tapLatency),
			.secondTapWindow(secondTapWindow),
			.doubleTapAbort(cfg_ff[CFG_DOUBLE_TAP_ABORT_BIT]),
			.singleEnable(cfg_ff[2*g]),
			.doubleEnable(cfg_ff[2*g+1]),
			.singleEvt(singleEvt[g]),
			.doubleEvt(doubleEvt[g]),
			.polarity(pol[g])
		);
	end

	always_comb begin
		anySingle = |singleEvt;
		anyDouble = |doubleEvt;
		anyEvt = anySingle || anyDouble;
		latchOn = cfg_ff[CFG_FLAG_LATCH_ENABLE_BIT];
		srcRead = regRdEn && regAddr == ADDR_TAP_SOURCE;
		nxt_cfg = cfg_ff;
		nxt_ths = ths_ff;
		nxt_timeLimit = timeLimit_ff;
		if (regWrEn) begin
			unique case (regAddr)
				ADDR_TAP_CONFIG: nxt_cfg = regWrData;
				ADDR_TAP_THRESHOLD_X: nxt_ths[0] = regWrData[6:0];
				ADDR_TAP_THRESHOLD_Y: nxt_ths[1] = regWrData[6:0];
				ADDR_TAP_THRESHOLD_Z: nxt_ths[2] = regWrData[6:0];
				ADDR_TAP_TIME_LIMIT: nxt_timeLimit = regWrData;
				default: ;
			endcase
		end
		nxt_rdData = 8'h00;
		if (regRdEn) begin
			unique case (regAddr)
				ADDR_TAP_CONFIG: nxt_rdData = cfg_ff;
				ADDR_TAP_SOURCE: nxt_rdData = src_ff;
				ADDR_TAP_THRESHOLD_X: nxt_rdData = {1'b0, ths_ff[0]};
				ADDR_TAP_THRESHOLD_Y: nxt_rdData = {1'b0, ths_ff[1]};
				ADDR_TAP_THRESHOLD_Z: nxt_rdData = {1'b0, ths_ff[2]};
				ADDR_TAP_TIME_LIMIT: nxt_rdData = timeLimit_ff;
				default: nxt_rdData = 8'h00;
			endcase
		end
		nxt_src = src_ff;
		if (srcRead)
			nxt_src = REG_RESET;
		// A new event in the read cycle wins; freeze applies only if unread
		if (anyEvt && (!latchOn || srcRead || !src_ff[SRC_EVENT_ACTIVE_BIT]))
		begin
			nxt_src[SRC_EVENT_ACTIVE_BIT] = 1'b1;
			nxt_src[SRC_AXIS_EVENT_LSB +: 3] = singleEvt | doubleEvt;
			nxt_src[SRC_DOUBLE_TAP_FLAG_BIT] = anyDouble;
			// Stale sign of a quiet axis would look like a negative tap
			nxt_src[SRC_POLARITY_LSB +: 3] = pol & (singleEvt | doubleEvt);
		end
		nxt_irq = nxt_src[SRC_EVENT_ACTIVE_BIT];
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			cfg_ff <= REG_RESET;
			src_ff <= REG_RESET;
			ths_ff <= '0;
			timeLimit_ff <= REG_RESET;
			rdData_ff <= 8'h00;
			irq_ff <= 1'b0;
		end else begin
			cfg_ff <= nxt_cfg;
			src_ff <= nxt_src;
			ths_ff <= nxt_ths;
			timeLimit_ff <= nxt_timeLimit;
			rdData_ff <= nxt_rdData;
			irq_ff <= nxt_irq;
		end
	end

	assign regRdData = rdData_ff;
	assign tapIrq = irq_ff;

	a_read_clears_src: assert property (@(posedge sys_clk) disable iff (!reset_n)
		srcRead && !anyEvt |=> src_ff == 8'h00 && !tapIrq)
		else $error("source not cleared by read");

	a_irq_tracks_ea: assert property (@(posedge sys_clk) disable iff (!reset_n)
		tapIrq == src_ff[SRC_EVENT_ACTIVE_BIT])
		else $error("interrupt differs from event-active");

	a_latch_freezes_src: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		latchOn && src_ff[SRC_EVENT_ACTIVE_BIT] && !srcRead |=> $stable(src_ff))
		else $error("latched source changed before read");

	a_nolatch_updates: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		!latchOn && anyDouble |=> src_ff[SRC_DOUBLE_TAP_FLAG_BIT]
		&& src_ff[SRC_EVENT_ACTIVE_BIT])
		else $error("unlatched event not reported");

	a_disabled_silent: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		cfg_ff[5:0] == 6'h00 && $past(cfg_ff[5:0]) == 6'h00
		&& !src_ff[SRC_EVENT_ACTIVE_BIT] |=> !src_ff[SRC_EVENT_ACTIVE_BIT])
		else $error("event reported while disabled");

	a_ths_top_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
		regRdEn && regAddr == ADDR_TAP_THRESHOLD_Z |=> !regRdData[7])
		else $error("threshold bit 7 not zero");

	a_cfg_write_read: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		regWrEn && regAddr == ADDR_TAP_CONFIG ##1 !regWrEn ##1 regRdEn
		&& !regWrEn && regAddr == ADDR_TAP_CONFIG
		|=> regRdData == $past(regWrData, 3))
		else $error("config readback mismatch");

	a_low_noise_cap: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		lowNoise |-> effThs[0] <= THRESHOLD_MAX_LOW_NOISE
		&& effThs[1] <= THRESHOLD_MAX_LOW_NOISE
		&& effThs[2] <= THRESHOLD_MAX_LOW_NOISE)
		else $error("threshold exceeds low-noise cap");

endmodule // tpd_tap_pulse_detector

// >>> test/tpd_host_model.sv
module tpd_host_model (
	input wire logic sys_clk,
	output logic [7:0] regAddr,
	output logic regWrEn,
	output logic [7:0] regWrData,
	output logic regRdEn,
	input wire logic [7:0] regRdData
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		regAddr = 8'h00;
		regWrEn = 1'b0;
		regWrData = 8'h00;
		regRdEn = 1'b0;
	end

	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(posedge sys_clk);
		regAddr <= addr;
		regWrData <= data;
		regWrEn <= 1'b1;
		@(posedge sys_clk);
		regWrEn <= 1'b0;
		// Stale data flipped so a late capture shows up
		regWrData <= ~data;
	endtask

	// Data stands one cycle after the taking edge only
	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
		@(posedge sys_clk);
		regAddr <= addr;
		regRdEn <= 1'b1;
		@(posedge sys_clk);
		regRdEn <= 1'b0;
		@(negedge sys_clk);
		data = regRdData;
	endtask
endmodule // tpd_host_model

// >>> test/tb_tap_pulse_detector.sv
module tb_tap_pulse_detector import tpd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int UNITS = 4;
	logic sys_clk, reset_n, sampleValid, tapLowpassEnable, lowNoise;
	logic [7:0] accel [3];
	logic [7:0] tapLatency, secondTapWindow, regAddr, regWrData, regRdData;
	logic [2:0] outputDataRate;
	logic [1:0] oversampleMode;
	logic regWrEn, regRdEn, tapIrq;
	logic [7:0] rd;
	int miscompares = 0;
	int checks_done = 0;
	typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r;} tb_row_type;
	tb_row_type rows [7] = '{
		'{ADDR_TAP_CONFIG, 8'ha5, 8'ha5}, '{ADDR_TAP_THRESHOLD_X, 8'hff, 8'h7f},
		'{ADDR_TAP_THRESHOLD_Y, 8'h81, 8'h01},
		'{ADDR_TAP_THRESHOLD_Z, 8'h7f, 8'h7f},
		'{ADDR_TAP_TIME_LIMIT, 8'hff, 8'hff},
		'{ADDR_TAP_SOURCE, 8'hff, 8'h00}, '{8'h30, 8'h55, 8'h00}};

	tpd_tap_pulse_detector #(.UNIT_CYCLES(UNITS)) i_dut (
		.sys_clk(sys_clk), .reset_n(reset_n), .sampleValid(sampleValid),
		.accelX(accel[0]), .accelY(accel[1]), .accelZ(accel[2]),
		.outputDataRate(outputDataRate), .oversampleMode(oversampleMode),
		.tapLowpassEnable(tapLowpassEnable), .lowNoise(lowNoise),
		.tapLatency(tapLatency), .secondTapWindow(secondTapWindow),
		.regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
		.regRdEn(regRdEn), .regRdData(regRdData), .tapIrq(tapIrq));

	tpd_host_model i_host (.sys_clk(sys_clk), .regAddr(regAddr),
		.regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
		.regRdData(regRdData));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// One sample every fourth cycle
	initial begin
		sampleValid = 1'b0;
		forever begin
			repeat (3) @(posedge sys_clk);
			sampleValid <= 1'b1;
			@(posedge sys_clk);
			sampleValid <= 1'b0;
		end
	end

	task automatic check(input string name, input logic [7:0] seen,
		input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic finish_test();
		if (miscompares == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic do_reset();
		reset_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		reset_n <= 1'b1;
	endtask

	task automatic pulse(input int ax, input logic [7:0] v, input int hold);
		@(posedge sys_clk);
		accel[ax] <= v;
		repeat (hold) @(posedge sys_clk);
		accel[ax] <= 8'h00;
	endtask

	// Source read, then a second read must find it cleared
	task automatic check_src(input logic [7:0] exp);
		repeat (24) @(posedge sys_clk);
		@(negedge sys_clk);
		check("tapIrq", {7'h00, tapIrq}, {7'h00, exp[7]});
		i_host.read_reg(ADDR_TAP_SOURCE, rd);
		check("tap_source", rd, exp);
		i_host.read_reg(ADDR_TAP_SOURCE, rd);
		check("tap_source cleared", rd, 8'h00);
		check("tapIrq cleared", {7'h00, tapIrq}, 8'h00);
	endtask

	task automatic run_tap(input logic [7:0] cfg, input int a1,
		input logic [7:0] v1, input int a2, input int hold,
		input logic [7:0] exp);
		i_host.write_reg(ADDR_TAP_CONFIG, cfg);
		pulse(a1, v1, hold);
		if (a2 >= 0) begin
			repeat (60) @(posedge sys_clk);
			pulse(a2, 8'h14, hold);
		end
		check_src(exp);
	endtask

	task automatic run_double(input logic [7:0] cfg, input logic [7:0] exp);
		// Earlier Z taps must leave latency and window first
		repeat (240) @(posedge sys_clk);
		i_host.write_reg(ADDR_TAP_CONFIG, cfg);
		pulse(2, 8'h14, 8);
		repeat (12) @(posedge sys_clk);
		pulse(2, 8'h14, 8);
		repeat (40) @(posedge sys_clk);
		pulse(2, 8'h14, 8);
		check_src(exp);
	endtask

	initial begin
		reset_n = 1'b0;
		accel = '{8'h00, 8'h00, 8'h00};
		outputDataRate = ODR_800;
		oversampleMode = OS_NORMAL;
		tapLowpassEnable = 1'b1;
		lowNoise = 1'b0;
		tapLatency = 8'h06;
		secondTapWindow = 8'h14;
		do_reset();
		foreach (rows[i]) begin
			i_host.write_reg(rows[i].a, rows[i].w);
			i_host.read_reg(rows[i].a, rd);
			check("register", rd, rows[i].r);
		end
		// Second reset in mid-run
		do_reset();
		@(negedge sys_clk);
		check("tapIrq at reset", {7'h00, tapIrq}, 8'h00);
		for (int a = 8'h21; a <= 8'h26; a++) begin
			i_host.read_reg(a[7:0], rd);
			check("reset value", rd, REG_RESET);
		end
		i_host.write_reg(ADDR_TAP_THRESHOLD_X, 8'h0a);
		i_host.write_reg(ADDR_TAP_THRESHOLD_Y, 8'h0a);
		i_host.write_reg(ADDR_TAP_THRESHOLD_Z, 8'h0a);
		i_host.write_reg(ADDR_TAP_TIME_LIMIT, 8'h04);
		run_tap(8'h41, 0, 8'h14, -1, 8, 8'h90);
		run_tap(8'h44, 1, 8'hec, -1, 8, 8'ha2);
		run_tap(8'h50, 2, 8'hec, -1, 8, 8'hc4);
		run_tap(8'h42, 0, 8'h14, -1, 8, 8'h00);
		run_tap(8'h41, 0, 8'h0a, -1, 8, 8'h00);
		run_tap(8'h41, 0, 8'h14, -1, 60, 8'h00);
		run_tap(8'h51, 0, 8'h14, 2, 8, 8'h90);
		run_tap(8'h11, 0, 8'h14, 2, 8, 8'hc0);
		run_double(8'h60, 8'hc8);
		run_double(8'he0, 8'h00);
		run_double(8'h20, 8'hc8);
		tapLowpassEnable <= 1'b0;
		run_tap(8'h41, 0, 8'h14, -1, 24, 8'h00);
		tapLowpassEnable <= 1'b1;
		run_tap(8'h41, 0, 8'h14, -1, 24, 8'h90);
		i_host.write_reg(ADDR_TAP_THRESHOLD_X, 8'h64);
		run_tap(8'h41, 0, 8'h50, -1, 8, 8'h00);
		lowNoise <= 1'b1;
		run_tap(8'h41, 0, 8'h50, -1, 8, 8'h90);
		finish_test();
	end

	initial begin
		repeat (30000) @(posedge sys_clk);
		miscompares++;
		finish_test();
	end
endmodule // tb_tap_pulse_detector
